// *** serial_rf_packetizer_bench.sv ***
// serial_rf_packetizer_bench: command and byte stream tests of the packetizer.
// assumes the radio sink model beside it; unit shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module serial_rf_packetizer_bench;
  import spkt_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic stall = 1'b0;
  logic rx_overflow, cmd_ack, cmd_err, pkt_valid, pkt_first, pkt_last;
  logic pkt_ready, tx_busy;
  logic [15:0] cmd_rdata;
  logic [7:0] pkt_data;
  logic [7:0] tx_byte = 8'h00;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  spkt_packetizer #(.UNIT_CYCLES(4)) i_dut (.ref_clk(ref_clk),
    .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_overflow(rx_overflow), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
    .cmd_err(cmd_err), .cmd_rdata(cmd_rdata), .pkt_valid(pkt_valid),
    .pkt_data(pkt_data), .pkt_first(pkt_first), .pkt_last(pkt_last),
    .pkt_ready(pkt_ready), .tx_busy(tx_busy));
  spkt_radio_sink i_sink (.ref_clk(ref_clk), .resetn(resetn), .stall(stall),
    .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_first(pkt_first),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // rdata returns the value held before the command; ack is due exactly
  // one cycle after the request, so no waiting is allowed here
  task cmd(input logic w, input logic [7:0] code, input logic [15:0] wd,
           input logic [15:0] exp_rd, input logic exp_err);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    chk({15'h0000, cmd_ack}, 16'h0001);
    chk({15'h0000, cmd_err}, {15'h0000, exp_err});
    chk(cmd_rdata, exp_rd);
  endtask : cmd
  task send(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= tx_byte;
      tx_byte = tx_byte + 8'h01;
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
  endtask : send
  task idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    cmd(1'b0, CMD_MAX_PACKET, 16'h0000, 16'h0040, 1'b0);
    cmd(1'b0, CMD_THRESHOLD, 16'h0000, 16'h0001, 1'b0);
    cmd(1'b1, CMD_MAX_PACKET, 16'h0101, 16'h0040, 1'b1);
    cmd(1'b1, CMD_MAX_PACKET, 16'h0100, 16'h0040, 1'b0);
    cmd(1'b1, CMD_THRESHOLD, 16'h0101, 16'h0001, 1'b1);
    cmd(1'b1, CMD_THRESHOLD, 16'h0100, 16'h0001, 1'b0);
    cmd(1'b0, 8'h55, 16'h0000, 16'h0000, 1'b1);
    cmd(1'b1, CMD_MAX_PACKET, 16'h0004, 16'h0100, 1'b0);
    cmd(1'b0, CMD_THRESHOLD, 16'h0000, 16'h0004, 1'b0);
    $display("settings test done");
    @(posedge ref_clk);
    stall <= 1'b1;
    send(2);
    idle(20);
    chk({15'h0000, tx_busy}, 16'h0000);
    send(8);
    idle(20);
    chk({15'h0000, pkt_valid}, 16'h0001);
    @(posedge ref_clk);
    stall <= 1'b0;
    idle(60);
    chk(16'(i_sink.lens.size()), 16'h0003);
    chk(16'(i_sink.lens[0]), 16'h0004);
    chk(16'(i_sink.lens[1]), 16'h0004);
    chk(16'(i_sink.lens[2]), 16'h0002);
    $display("threshold stream test done");
    cmd(1'b1, CMD_THRESHOLD, 16'h0000, 16'h0004, 1'b0);
    cmd(1'b1, CMD_TIMEOUT, 16'h0000, 16'h0000, 1'b0);
    send(1);
    idle(50);
    chk({15'h0000, tx_busy}, 16'h0000);
    cmd(1'b1, CMD_TIMEOUT, 16'h0003, 16'h0000, 1'b0);
    idle(30);
    chk(16'(i_sink.lens.size()), 16'h0004);
    chk(16'(i_sink.lens[3]), 16'h0001);
    repeat (4) begin
      send(1);
      idle(6);
    end
    chk(16'(i_sink.lens.size()), 16'h0004);
    idle(40);
    chk(16'(i_sink.lens[4]), 16'h0004);
    chk(16'(i_sink.bad), 16'h0000);
    $display("silence timeout test done");
    cmd(1'b1, CMD_MAX_PACKET, 16'h0000, 16'h0004, 1'b0);
    send(257);
    #1;
    chk({15'h0000, rx_overflow}, 16'h0001);
    idle(1);
    chk({15'h0000, rx_overflow}, 16'h0000);
    chk({15'h0000, tx_busy}, 16'h0000);
    cmd(1'b1, CMD_MAX_PACKET, 16'h0040, 16'h0000, 1'b0);
    idle(20);
    chk({15'h0000, tx_busy}, 16'h0001);
    idle(300);
    chk(16'(i_sink.lens.size()), 16'h0009);
    chk(16'(i_sink.lens[5]), 16'h0040);
    chk(16'(i_sink.lens[8]), 16'h0040);
    chk({15'h0000, tx_busy}, 16'h0000);
    chk(16'(i_sink.bad), 16'h0000);
    $display("buffer full test done");
    end_sim();
  end
endmodule : serial_rf_packetizer_bench
`default_nettype wire

// *** spkt_packetizer.sv ***
// spkt_packetizer: buffers serial bytes and cuts them into radio packets.
// assumes the command port and radio sink share ref_clk; the radio side
// uses valid/ready and may stall.
`timescale 1ns/1ps
`default_nettype none
module spkt_packetizer
  import spkt_pkg::*;
#(
  parameter int UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_overflow,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ack,
  output logic cmd_err,
  output logic [15:0] cmd_rdata,
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_first,
  output logic pkt_last,
  input wire logic pkt_ready,
  output logic tx_busy
);
  logic [7:0] serial_input_buffer [BUF_DEPTH];
  logic [7:0] wr_ptr;
  logic [7:0] rd_ptr;
  logic [8:0] count;
  logic [8:0] max_packet_bytes;
  logic [8:0] tx_threshold_bytes;
  logic [15:0] serial_silence_timeout;
  logic [8:0] remain;
  logic pkt_is_first;
  spkt_state_e state;
  logic push;
  logic pop;
  logic out_free;
  logic thr_hit;
  logic can_start;
  logic [8:0] next_len;

  spkt_timer_if tif();
  assign tif.byte_seen = rx_valid;
  assign tif.timeout = serial_silence_timeout;

  spkt_silence_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tif(tif)
  );

  // bytes arriving into a full buffer are dropped and flagged
  assign push = rx_valid && (count != BUF_FULL);
  assign out_free = !pkt_valid || pkt_ready;
  assign pop = (state == SPKT_SEND) && out_free && (remain != 9'h000);
  assign thr_hit = (tx_threshold_bytes != 9'h000) &&
                   (count >= tx_threshold_bytes);
  assign can_start = (count != 9'h000) &&
                     (max_packet_bytes != 9'h000) &&
                     (thr_hit || tif.expired);
  assign next_len = spkt_min(count, max_packet_bytes);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      serial_input_buffer[wr_ptr] <= rx_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 8'h00;
      rd_ptr <= 8'h00;
      count <= 9'h000;
      rx_overflow <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 8'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 8'h01;
      end
      count <= count + {8'h00, push} - {8'h00, pop};
      rx_overflow <= rx_valid && !push;
    end
  end

  // settings port: one-cycle ack, err for bad code or out-of-range value
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      max_packet_bytes <= MAX_PACKET_RESET;
      tx_threshold_bytes <= THRESHOLD_RESET;
      serial_silence_timeout <= TIMEOUT_RESET;
      cmd_ack <= 1'b0;
      cmd_err <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      cmd_ack <= cmd_valid;
      cmd_err <= 1'b0;
      if (cmd_valid) begin
        unique case (cmd_code)
          CMD_MAX_PACKET: begin
            cmd_rdata <= {7'h00, max_packet_bytes};
            if (cmd_write) begin
              if (cmd_wdata > {7'h00, MAX_PACKET_CEIL}) begin
                cmd_err <= 1'b1;
              end else begin
                max_packet_bytes <= cmd_wdata[8:0];
                if (cmd_wdata[8:0] < tx_threshold_bytes) begin
                  tx_threshold_bytes <= cmd_wdata[8:0];
                end
              end
            end
          end
          CMD_THRESHOLD: begin
            cmd_rdata <= {7'h00, tx_threshold_bytes};
            if (cmd_write) begin
              if (cmd_wdata > {7'h00, max_packet_bytes}) begin
                cmd_err <= 1'b1;
              end else begin
                tx_threshold_bytes <= cmd_wdata[8:0];
              end
            end
          end
          CMD_TIMEOUT: begin
            cmd_rdata <= serial_silence_timeout;
            if (cmd_write) begin
              serial_silence_timeout <= cmd_wdata;
            end
          end
          default: begin
            cmd_rdata <= 16'h0000;
            cmd_err <= 1'b1;
          end
        endcase
      end
    end
  end

  // the output byte is registered so the radio sees stable data under stall
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SPKT_IDLE;
      remain <= 9'h000;
      pkt_is_first <= 1'b0;
      pkt_valid <= 1'b0;
      pkt_data <= 8'h00;
      pkt_first <= 1'b0;
      pkt_last <= 1'b0;
      tx_busy <= 1'b0;
    end else begin
      unique case (state)
        SPKT_IDLE: begin
          tx_busy <= 1'b0;
          if (can_start) begin
            remain <= next_len;
            pkt_is_first <= 1'b1;
            tx_busy <= 1'b1;
            state <= SPKT_SEND;
          end
        end
        SPKT_SEND: begin
          if (out_free) begin
            if (remain != 9'h000) begin
              pkt_valid <= 1'b1;
              pkt_data <= serial_input_buffer[rd_ptr];
              pkt_first <= pkt_is_first;
              pkt_last <= (remain == 9'h001);
              pkt_is_first <= 1'b0;
              remain <= remain - 9'h001;
            end else begin
              pkt_valid <= 1'b0;
              pkt_first <= 1'b0;
              pkt_last <= 1'b0;
              state <= SPKT_NEXT;
            end
          end
        end
        SPKT_NEXT: begin
          // follow-on packets bypass threshold and timeout
          if (count != 9'h000 && max_packet_bytes != 9'h000) begin
            remain <= next_len;
            pkt_is_first <= 1'b1;
            state <= SPKT_SEND;
          end else begin
            tx_busy <= 1'b0;
            state <= SPKT_IDLE;
          end
        end
        default: begin
          state <= SPKT_IDLE;
        end
      endcase
    end
  end

  // helper: bytes sent in the current packet, for checking the cap
  logic [8:0] sent_in_pkt;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sent_in_pkt <= 9'h000;
    end else if (pkt_valid && pkt_ready) begin
      sent_in_pkt <= pkt_last ? 9'h000 : sent_in_pkt + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // settings stay inside their ranges
  a_thr_below_max: assert property (
    tx_threshold_bytes <= max_packet_bytes)
    else $error("threshold above packet size");
  a_max_in_range: assert property (
    max_packet_bytes <= MAX_PACKET_CEIL)
    else $error("packet size above ceiling");

  // command port: good writes land, refused ones leave settings alone
  a_max_accept: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_MAX_PACKET &&
    cmd_wdata <= 16'h0100
    |=> !cmd_err && max_packet_bytes == $past(cmd_wdata[8:0]))
    else $error("valid packet size write not taken");
  a_max_reject: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_MAX_PACKET &&
    cmd_wdata > 16'h0100
    |=> cmd_err && $stable(max_packet_bytes))
    else $error("out-of-range packet size write taken");
  a_shrink_thr: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_MAX_PACKET &&
    cmd_wdata <= 16'h0100 && cmd_wdata[8:0] < tx_threshold_bytes
    |=> tx_threshold_bytes == $past(cmd_wdata[8:0]))
    else $error("threshold not lowered with packet size");
  a_thr_accept: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_THRESHOLD &&
    cmd_wdata <= {7'h00, max_packet_bytes}
    |=> !cmd_err && tx_threshold_bytes == $past(cmd_wdata[8:0]))
    else $error("valid threshold write not taken");
  a_thr_reject: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_THRESHOLD &&
    cmd_wdata > {7'h00, max_packet_bytes}
    |=> cmd_err && $stable(tx_threshold_bytes))
    else $error("threshold above packet size taken");
  a_bad_code: assert property (
    cmd_valid && cmd_code != CMD_MAX_PACKET &&
    cmd_code != CMD_THRESHOLD && cmd_code != CMD_TIMEOUT
    |=> cmd_err && cmd_rdata == 16'h0000)
    else $error("unknown command not refused");
  a_cmd_ack: assert property (
    cmd_valid |=> cmd_ack ##1 !cmd_ack || $past(cmd_valid))
    else $error("command not acknowledged next cycle");
  a_err_with_ack: assert property (
    cmd_err |-> cmd_ack)
    else $error("command error without acknowledge");

  // launch needs buffered data and one enabled criterion
  a_no_start_empty: assert property (
    state == SPKT_IDLE && count == 9'h000 |=> state == SPKT_IDLE)
    else $error("transmission started with empty buffer");
  a_zero_criteria: assert property (
    state == SPKT_IDLE && tx_threshold_bytes == 9'h000 &&
    serial_silence_timeout == 16'h0000 |=> state == SPKT_IDLE)
    else $error("start without an enabled criterion");
  a_timer_zero: assert property (
    serial_silence_timeout == 16'h0000 |-> !tif.expired)
    else $error("silence expiry with timeout disabled");
  a_thr_start: assert property (
    state == SPKT_IDLE && count != 9'h000 &&
    max_packet_bytes != 9'h000 && tx_threshold_bytes != 9'h000 &&
    count >= tx_threshold_bytes |=> state == SPKT_SEND && tx_busy)
    else $error("threshold reached but no launch");
  a_timeout_start: assert property (
    state == SPKT_IDLE && count != 9'h000 &&
    max_packet_bytes != 9'h000 && tif.expired
    |=> state == SPKT_SEND && tx_busy)
    else $error("silence expired but no launch");
  a_launch_len: assert property (
    state != SPKT_SEND ##1 state == SPKT_SEND
    |-> remain == spkt_min($past(count), $past(max_packet_bytes)))
    else $error("packet length not min of count and size");

  // streaming and the byte stream itself
  a_stream_on: assert property (
    state == SPKT_NEXT && count != 9'h000 && max_packet_bytes != 9'h000
    |=> state == SPKT_SEND && tx_busy)
    else $error("streaming stopped with data left");
  a_busy_level: assert property (
    tx_busy == (state != SPKT_IDLE))
    else $error("busy flag out of step with sender");
  a_pkt_size_cap: assert property (
    pkt_valid |-> sent_in_pkt < max_packet_bytes)
    else $error("packet longer than packet size setting");
  a_stall_hold: assert property (
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data) &&
    $stable(pkt_first) && $stable(pkt_last))
    else $error("packet byte changed while stalled");
  a_first_flag: assert property (
    state == SPKT_SEND && pkt_is_first && out_free && remain != 9'h000
    |=> pkt_valid && pkt_first)
    else $error("first byte of packet not marked");
  a_pop_has_data: assert property (
    pop |-> count != 9'h000)
    else $error("byte taken from empty buffer");
endmodule : spkt_packetizer
`default_nettype wire

// *** spkt_pkg.sv ***
// spkt_pkg: constants and types for the serial-to-radio packetizer.
// assumes a single 100 MHz clock and a command port with 8-bit codes and 16-bit data.
// How it works
// - packet size setting spans 0 to 0x100
// - packet size resets to 0x40
// - no packet exceeds packet size setting
// - packet size reached through command 0x29
// - threshold never exceeds packet size
// - shrinking packet size pulls threshold down
// - threshold accepts 0 up to packet size
// - threshold resets to 1, command 0x20
// - start needs buffered data and criterion
// - silence timeout starts send unless zero
// - threshold byte count starts send unless zero
// - criteria gate only the first packet
// - keep streaming packets until buffer empty
// - timeout 0..0xFFFF, 200 us, restarts per byte
package spkt_pkg;
  localparam logic [7:0] CMD_THRESHOLD = 8'h20;
  localparam logic [7:0] CMD_TIMEOUT = 8'h21;
  localparam logic [7:0] CMD_MAX_PACKET = 8'h29;
  localparam logic [8:0] MAX_PACKET_CEIL = 9'h100;
  localparam logic [8:0] MAX_PACKET_RESET = 9'h040;
  localparam logic [8:0] THRESHOLD_RESET = 9'h001;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam int BUF_DEPTH = 256;
  localparam logic [8:0] BUF_FULL = 9'h100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_UNIT_NS = 200000;
  localparam int TIMEOUT_UNIT_CYCLES = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SPKT_IDLE = 2'b00,
    SPKT_SEND = 2'b01,
    SPKT_NEXT = 2'b11
  } spkt_state_e;

  function automatic logic [8:0] spkt_min(input logic [8:0] a,
                                          input logic [8:0] b);
    spkt_min = (a < b) ? a : b;
  endfunction : spkt_min
endpackage : spkt_pkg

// *** spkt_radio_sink.sv ***
// spkt_radio_sink: radio side model; takes packet bytes, records lengths.
// assumes pkt_* keep valid/ready on ref_clk and bytes count up from 0.
`timescale 1ns/1ps
`default_nettype none
module spkt_radio_sink (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_first,
  input wire logic pkt_last,
  output logic pkt_ready
);
  int lens[$];
  int cur;
  int bad;
  logic [7:0] next_byte;
  // a stalled radio holds ready low for as long as the bench asks
  assign pkt_ready = !stall;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cur = 0;
      bad = 0;
      next_byte = 8'h00;
    end else if (pkt_valid && pkt_ready) begin
      if (pkt_data !== next_byte || pkt_first !== (cur == 0)) begin
        bad = bad + 1;
      end
      next_byte = next_byte + 8'h01;
      cur = cur + 1;
      if (pkt_last === 1'b1) begin
        lens.push_back(cur);
        cur = 0;
      end
    end
  end
endmodule : spkt_radio_sink
`default_nettype wire

// *** spkt_silence_timer.sv ***
// spkt_silence_timer: measures uninterrupted serial silence in 200 us units.
// assumes byte_seen pulses once per received byte.
`timescale 1ns/1ps
`default_nettype none
module spkt_silence_timer
  import spkt_pkg::*;
#(
  parameter int UNIT_CYCLES = TIMEOUT_UNIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  spkt_timer_if.timer tif
);
  logic [15:0] pre_cnt;
  logic [15:0] units;
  logic tick;

  assign tick = (pre_cnt == 16'(UNIT_CYCLES - 1));

  // any byte restarts both the prescaler and the unit count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= 16'h0000;
    end else if (tif.byte_seen || tick) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      units <= 16'h0000;
    end else if (tif.byte_seen) begin
      units <= 16'h0000;
    end else if (tick && units != 16'hFFFF) begin
      units <= units + 16'h0001;
    end
  end

  // zero disables the criterion
  assign tif.expired = (tif.timeout != 16'h0000) &&
                       (units >= tif.timeout);

  a_byte_restarts: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    tif.byte_seen |=> units == 16'h0000 && pre_cnt == 16'h0000)
    else $error("silence count not restarted by byte");
endmodule : spkt_silence_timer
`default_nettype wire

// *** spkt_timer_if.sv ***
// spkt_timer_if: link between the packetizer and its silence timer.
// assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface spkt_timer_if;
  logic byte_seen;
  logic [15:0] timeout;
  logic expired;
  modport ctrl (output byte_seen, output timeout, input expired);
  modport timer (input byte_seen, input timeout, output expired);
endinterface : spkt_timer_if
`default_nettype wire
